// file: core/spie_core.v
// Serial port error detection, flag clearing and interrupt requests
// Summary of operation
// - Master sees select low: mode fault
// - Mode fault raises receiver/error request
// - Mode fault clears enable bit
// - Mode fault clears master select bit
// - Select pin low sets fault when enabled
// - Select disable ignores pin, no fault
// - Fault cleared by status read, control write
// - Data write while busy sets collision
// - Collision: no request, transfer continues
// - Collision cleared by status then data access
// - Overrun keeps first byte, drops later
// - Overrun is neither detected nor flagged
// - Slave select released early sets error
// - Early release error cleared by disable
// - Transfer done sets flag and transmit request
// - Fault request only while disable bit clear
// - Status register at C4 upper bits
// - Control register at C3
`timescale 1ns/10ps
`default_nettype none
`include "spie_defs.vh"
module spie_core (
  input  wire       i_core_clk,
  input  wire       i_rstn,
  input  wire [7:0] i_addr,
  input  wire       i_wr,
  input  wire       i_rd,
  input  wire [7:0] i_wdata,
  input  wire       i_sck,
  input  wire       i_ss_n,
  input  wire       i_mosi,
  input  wire       i_miso,
  output reg  [7:0] o_rdata,
  output reg        o_sck,
  output reg        o_mosi,
  output reg        o_miso,
  output reg        o_miso_oe_n,
  output reg        o_tx_irq,
  output reg        o_rx_err_irq,
  output reg        o_irq
);

  // Register addresses decoded once as functions
  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // Control copy and its next value
  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  reg       done_reg;
  reg       write_collision_flag_reg;
  reg       select_early_release_flag_reg;
  reg       mode_fault_flag_reg;
  reg       mode_fault_flag_armed_reg;
  reg       write_collision_flag_armed_reg;
  reg [7:0] rx_buf_reg;
  reg [7:0] tx_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg       busy_reg;
  reg       tx_pending_reg;
  reg [`SPIE_DIV_BITS-1:0] div_reg;
  // Pin synchronisers and edge history
  reg [1:0] sck_sync_reg;
  reg [1:0] ss_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [1:0] miso_sync_reg;
  reg       sck_prev_reg;
  reg       ss_prev_reg;

  // Decoded control bits, pin edges and register strobes
  wire enable   = ctrl_reg[`SPIE_CTL_ENABLE];
  wire select_pin_disable_bit    = ctrl_reg[`SPIE_CTL_SELECT_PIN_DISABLE_BIT];
  wire master   = ctrl_reg[`SPIE_CTL_MASTER];
  wire sck_s    = sck_sync_reg[1];
  wire ss_s     = ss_sync_reg[1];
  wire sck_rise = sck_s & ~sck_prev_reg;
  wire sck_fall = ~sck_s & sck_prev_reg;
  wire wr_ctrl  = i_wr & is_addr(i_addr, `SPIE_CTRL_ADDR);
  wire wr_data  = i_wr & is_addr(i_addr, `SPIE_DATA_ADDR);
  wire rd_stat  = i_rd & is_addr(i_addr, `SPIE_STAT_ADDR);
  wire rd_data  = i_rd & is_addr(i_addr, `SPIE_DATA_ADDR);
  wire div_tick = (div_reg == {`SPIE_DIV_BITS{1'b1}});
  // Slave selected when pin low (pin ignored if disable bit set)
  wire slave_sel = ~master & enable & (select_pin_disable_bit | ~ss_s);

  // Master fault when select pin is pulled low
  wire mode_fault_flag_event = enable & master & ~select_pin_disable_bit & ~ss_s;
  // Select released mid byte in slave mode
  wire select_early_release_flag_event = enable & ~master & ~select_pin_disable_bit & ss_s & ~ss_prev_reg & busy_reg;
  // Master byte ends on last divided edge; slave on eighth sample
  wire m_done = master & busy_reg & div_tick & o_sck & (bit_cnt_reg == `SPIE_BITS_PER_BYTE - 4'h1);
  wire s_done = slave_sel & sck_rise & (bit_cnt_reg == `SPIE_BITS_PER_BYTE - 4'h1);
  wire byte_done = m_done | s_done;
  // Received byte including the bit sampled on this edge
  wire [7:0] rx_byte = {shift_reg[6:0], master ? miso_sync_reg[1] : mosi_sync_reg[1]};

  // Two-stage synchronisers for every pin input
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      sck_sync_reg  <= 2'h0;
      ss_sync_reg   <= 2'h3;
      mosi_sync_reg <= 2'h0;
      miso_sync_reg <= 2'h0;
      sck_prev_reg  <= 1'b0;
      ss_prev_reg   <= 1'b1;
    end else begin
      sck_sync_reg  <= {sck_sync_reg[0], i_sck};
      ss_sync_reg   <= {ss_sync_reg[0], i_ss_n};
      mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
      miso_sync_reg <= {miso_sync_reg[0], i_miso};
      sck_prev_reg  <= sck_s;
      ss_prev_reg   <= ss_s;
    end
  end

  // Control register next value
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = i_wdata;
    end
    if (mode_fault_flag_event) begin
      ctrl_next[`SPIE_CTL_ENABLE] = 1'b0;
      ctrl_next[`SPIE_CTL_MASTER] = 1'b0;
    end
  end

  // Control register and status flags
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      ctrl_reg       <= `SPIE_CTRL_RESET;
      mode_fault_flag_reg       <= 1'b0;
      mode_fault_flag_armed_reg <= 1'b0;
      write_collision_flag_reg       <= 1'b0;
      write_collision_flag_armed_reg <= 1'b0;
      select_early_release_flag_reg      <= 1'b0;
      done_reg       <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      // Status read arms, control write clears; set wins
      if (rd_stat && mode_fault_flag_reg) begin
        mode_fault_flag_armed_reg <= 1'b1;
      end else if (wr_ctrl) begin
        mode_fault_flag_armed_reg <= 1'b0;
      end
      if (mode_fault_flag_event) begin
        mode_fault_flag_reg <= 1'b1;
      end else if (wr_ctrl && mode_fault_flag_armed_reg) begin
        mode_fault_flag_reg <= 1'b0;
      end
      // Status access then data access clears
      if (rd_stat) begin
        write_collision_flag_armed_reg <= 1'b1;
      end else if (wr_data || rd_data) begin
        write_collision_flag_armed_reg <= 1'b0;
      end
      if (wr_data && busy_reg) begin
        write_collision_flag_reg <= 1'b1;
      end else if ((wr_data || rd_data) && write_collision_flag_armed_reg) begin
        write_collision_flag_reg <= 1'b0;
      end
      // Cleared only by enable going low
      if (select_early_release_flag_event) begin
        select_early_release_flag_reg <= 1'b1;
      end else if (!enable) begin
        select_early_release_flag_reg <= 1'b0;
      end
      // Byte completion sets done; status then data clears
      if (byte_done) begin
        done_reg <= 1'b1;
      end else if ((wr_data || rd_data) && write_collision_flag_armed_reg) begin
        done_reg <= 1'b0;
      end
    end
  end

  // Shift engine: master drives clock, slave follows pin clock
  always @(posedge i_core_clk) begin
    if (!i_rstn || !enable || select_early_release_flag_event) begin
      busy_reg       <= 1'b0;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      div_reg        <= {`SPIE_DIV_BITS{1'b0}};
      o_sck          <= 1'b0;
      tx_pending_reg <= 1'b0;
      if (!i_rstn) begin
        tx_reg     <= 8'h00;
        rx_buf_reg <= 8'h00;
      end
    end else begin
      div_reg <= div_reg + {{(`SPIE_DIV_BITS-1){1'b0}}, 1'b1};
      // Colliding write is dropped, transfer continues
      if (wr_data && !busy_reg) begin
        tx_reg         <= i_wdata;
        tx_pending_reg <= master;
        shift_reg      <= i_wdata;
      end
      if (master) begin
        if (!busy_reg && tx_pending_reg && div_tick) begin
          busy_reg       <= 1'b1;
          tx_pending_reg <= 1'b0;
          bit_cnt_reg    <= 4'h0;
        end else if (busy_reg && div_tick) begin
          o_sck <= ~o_sck;
          if (o_sck) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (m_done) begin
              busy_reg <= 1'b0;
            end
          end
        end
      end else if (slave_sel && sck_rise) begin
        shift_reg   <= rx_byte;
        busy_reg    <= ~s_done;
        bit_cnt_reg <= s_done ? 4'h0 : bit_cnt_reg + 4'h1;
      end
      // Keep first byte since flag cleared
      if (byte_done && !done_reg) begin
        rx_buf_reg <= rx_byte;
      end
    end
  end

  // Serial outputs and read data, all registered
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_mosi      <= 1'b0;
      o_miso      <= 1'b0;
      o_miso_oe_n <= 1'b1;
      o_rdata     <= 8'h00;
    end else begin
      o_mosi      <= master & shift_reg[7];
      o_miso      <= shift_reg[7];
      o_miso_oe_n <= ~(slave_sel & ~sck_fall | slave_sel);
      // Flags in the upper status nibble
      if (rd_stat) begin
        o_rdata <= {done_reg, write_collision_flag_reg, select_early_release_flag_reg, mode_fault_flag_reg, 4'h0};
      end else if (is_addr(i_addr, `SPIE_CTRL_ADDR) && i_rd) begin
        o_rdata <= ctrl_reg;
      end else if (rd_data) begin
        o_rdata <= rx_buf_reg;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // Interrupt requests
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_tx_irq     <= 1'b0;
      o_rx_err_irq <= 1'b0;
      o_irq        <= 1'b0;
    end else begin
      o_tx_irq     <= done_reg;
      // Only while select disable is clear
      o_rx_err_irq <= mode_fault_flag_reg & ~select_pin_disable_bit;
      o_irq        <= done_reg | (mode_fault_flag_reg & ~select_pin_disable_bit);
    end
  end

endmodule // spie_core
`default_nettype wire

// file: shared/spie_defs.vh
// Constants for the serial error and interrupt logic
`ifndef SPIE_DEFS_VH
`define SPIE_DEFS_VH
`define SPIE_CTRL_ADDR    8'hC3
`define SPIE_STAT_ADDR    8'hC4
`define SPIE_DATA_ADDR    8'hC5
`define SPIE_CTRL_RESET   8'h14
`define SPIE_CTL_ENABLE   6
`define SPIE_CTL_SELECT_PIN_DISABLE_BIT    5
`define SPIE_CTL_MASTER   4
`define SPIE_CTL_CPHA     2
`define SPIE_ST_DONE      7
`define SPIE_ST_WRITE_COLLISION_FLAG      6
`define SPIE_ST_SELECT_EARLY_RELEASE_FLAG     5
`define SPIE_ST_MODE_FAULT_FLAG      4
`define SPIE_BITS_PER_BYTE 4'h8
`define SPIE_DIV_BITS     3
`endif

// file: verif/spie_monitor.sv
// Port checker for the serial error and interrupt logic
`timescale 1ns/10ps
`default_nettype none
module spie_monitor (
  input wire logic       i_core_clk,
  input wire logic       i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic       i_ss_n,
  input wire logic [7:0] o_rdata,
  input wire logic       o_tx_irq,
  input wire logic       o_rx_err_irq,
  input wire logic       o_irq
);
  logic [7:0] ctl_reg;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // Control shadow; a fault drops enable and master
  always @(posedge i_core_clk) begin
    if (!i_rstn) ctl_reg <= 8'h14;
    else if (i_wr && i_addr == 8'hC3) ctl_reg <= i_wdata;
    else if ($rose(o_rx_err_irq)) ctl_reg <= ctl_reg & 8'hAF;
  end
  // Select falls on an enabled master that watches its pin
  sequence ss_fall_master;
    ctl_reg[6] && ctl_reg[4] && !ctl_reg[5] && $fell(i_ss_n);
  endsequence
  sequence select_pin_disable_bit_held;
    ctl_reg[5] [*3];
  endsequence
  AST_MODE_FAULT_FLAG_REQ: assert property (ss_fall_master |-> ##[3:6] o_rx_err_irq)
    else $error("mode fault request missing");
  AST_SELECT_PIN_DISABLE_BIT_QUIET: assert property (select_pin_disable_bit_held |-> !o_rx_err_irq)
    else $error("fault request while pin ignored");
  AST_IRQ_OR: assert property (o_irq == (o_tx_irq | o_rx_err_irq))
    else $error("combined request wrong");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero when idle");
  AST_DONE_READ: assert property (i_rd && i_addr == 8'hC4 |=> o_rdata[7] == o_tx_irq)
    else $error("done bit and transmit request differ");
  AST_MODE_FAULT_FLAG_READ: assert property (i_rd && i_addr == 8'hC4 && !ctl_reg[5]
    |=> o_rdata[4] == o_rx_err_irq)
    else $error("fault bit and error request differ");
  AST_STAT_LOW: assert property (i_rd && i_addr == 8'hC4 |=> o_rdata[3:0] == 4'h0)
    else $error("status low bits not zero");
  AST_TX_DONE: assert property (i_wr && i_addr == 8'hC5 && ctl_reg[6] && ctl_reg[4]
    |-> ##[2:200] o_tx_irq)
    else $error("transfer never completed");
endmodule // spie_monitor
bind spie_core spie_monitor u_spie_monitor (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_ss_n(i_ss_n),
  .o_rdata(o_rdata), .o_tx_irq(o_tx_irq), .o_rx_err_irq(o_rx_err_irq), .o_irq(o_irq));
`default_nettype wire

// file: verif/spie_slave_model.sv
// Remote serial slave answering the master, MSB first
`timescale 1ns/10ps
`default_nettype none
module spie_slave_model (
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  output var  logic       o_miso,
  output var  logic [7:0] o_last_byte
);
  logic [7:0] tx_reg = 8'h3C;
  logic [7:0] sh_reg = 8'h00;
  int         bit_cnt = 0;
  initial o_miso = 1'h1;
  initial o_last_byte = 8'h00;
  // Leading edge drives the next bit
  always @(posedge i_sck) begin
    o_miso <= tx_reg[7 - bit_cnt];
  end
  // Trailing edge samples; after a byte the line shows the inverse
  always @(negedge i_sck) begin
    sh_reg = {sh_reg[6:0], i_mosi};
    bit_cnt <= (bit_cnt == 7) ? 0 : bit_cnt + 1;
    if (bit_cnt == 7) begin
      o_last_byte <= sh_reg;
      tx_reg <= tx_reg + 8'h11;
      o_miso <= ~o_miso;
    end
  end
endmodule // spie_slave_model
`default_nettype wire

// file: verif/test_spie_core.sv
// Self-checking bench for the serial error and interrupt logic
`timescale 1ns/10ps
`default_nettype none
module test_spie_core;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [7:0]  wdata = 8'h00;
  logic        sck = 1'h0;
  logic        ss_n = 1'h1;
  logic        mosi = 1'h0;
  logic [7:0]  rdata, got_byte;
  logic        m_sck, m_mosi, s_miso, tx_irq, rx_irq, irq;
  logic        s_out, oe_n;
  int          fail_count = 0;
  int          check_count = 0;
  // Rows: address, write, write data, expected read data
  logic [24:0] rows [5] = '{{8'hC3, 1'h0, 8'h00, 8'h14}, {8'hC4, 1'h0, 8'h00, 8'h00},
    {8'hC7, 1'h0, 8'h00, 8'h00}, {8'hC3, 1'h1, 8'h54, 8'h00}, {8'hC3, 1'h0, 8'h00, 8'h54}};
  spie_core u_spie_core (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr(wr),
    .i_rd(rd), .i_wdata(wdata), .i_sck(sck), .i_ss_n(ss_n), .i_mosi(mosi), .i_miso(s_miso),
    .o_rdata(rdata), .o_sck(m_sck), .o_mosi(m_mosi), .o_miso(s_out), .o_miso_oe_n(oe_n),
    .o_tx_irq(tx_irq), .o_rx_err_irq(rx_irq), .o_irq(irq));
  spie_slave_model u_spie_slave_model (.i_sck(m_sck), .i_mosi(m_mosi), .o_miso(s_miso),
    .o_last_byte(got_byte));
  always #5 clk = ~clk;
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One register access; reads are compared the cycle after
  task automatic op(input logic [7:0] a, input logic w, input logic [7:0] d,
                    input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1;
    if (!w) chk("rdata", e, rdata);
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    foreach (rows[i]) op(rows[i][24:17], rows[i][16], rows[i][15:8], rows[i][7:0]);
    op(8'hC5, 1'h1, 8'hA5, 8'h00);
    repeat (20) @(posedge clk);
    op(8'hC5, 1'h1, 8'hFF, 8'h00);
    repeat (160) @(posedge clk);
    chk("first byte", 8'hA5, got_byte);
    chk("tx irq", 8'h01, {7'h0, tx_irq});
    chk("err irq", 8'h00, {7'h0, rx_irq});
    op(8'hC5, 1'h1, 8'h5A, 8'h00);
    repeat (160) @(posedge clk);
    chk("second byte", 8'h5A, got_byte);
    op(8'hC4, 1'h0, 8'h00, 8'hC0);
    op(8'hC5, 1'h0, 8'h00, 8'h3C);
    op(8'hC4, 1'h0, 8'h00, 8'h00);
    @(posedge clk);
    ss_n <= 1'h0;
    repeat (8) @(posedge clk);
    ss_n <= 1'h1;
    #1 chk("irq", 8'h01, {7'h0, irq});
    op(8'hC3, 1'h1, 8'h04, 8'h00);
    op(8'hC3, 1'h0, 8'h00, 8'h04);
    op(8'hC4, 1'h0, 8'h00, 8'h10);
    op(8'hC3, 1'h1, 8'h04, 8'h00);
    op(8'hC4, 1'h0, 8'h00, 8'h00);
    op(8'hC3, 1'h1, 8'h74, 8'h00);
    @(posedge clk);
    ss_n <= 1'h0;
    repeat (10) @(posedge clk);
    ss_n <= 1'h1;
    op(8'hC4, 1'h0, 8'h00, 8'h00);
    op(8'hC3, 1'h1, 8'h44, 8'h00);
    @(posedge clk);
    ss_n <= 1'h0;
    // Remote master sends three bits, then lets go of select
    repeat (3) begin
      repeat (8) @(posedge clk);
      sck <= 1'h1;
      repeat (8) @(posedge clk);
      sck <= 1'h0;
    end
    chk("miso oe", 8'h00, {7'h0, oe_n});
    chk("miso", 8'h00, {7'h0, s_out});
    ss_n <= 1'h1;
    repeat (8) @(posedge clk);
    op(8'hC4, 1'h0, 8'h00, 8'h20);
    chk("irq", 8'h00, {7'h0, irq});
    op(8'hC3, 1'h1, 8'h04, 8'h00);
    op(8'hC4, 1'h0, 8'h00, 8'h00);
    @(posedge clk);
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    op(8'hC3, 1'h0, 8'h00, 8'h14);
    tally_and_finish();
  end
endmodule // test_spie_core
`default_nettype wire
